// file: src/video_capture_serial_control_map.vh
`ifndef VIDEO_CAPTURE_SERIAL_CONTROL_MAP_VH
`define VIDEO_CAPTURE_SERIAL_CONTROL_MAP_VH
// Register indices
`define REG_PLL_DIV_HIGH        4'h0
`define REG_PLL_DIV_LOW         4'h1
`define REG_CLAMP_START         4'h8
`define REG_CLAMP_LENGTH        4'h9
`define REG_GENERAL_CONTROL_ONE 4'hA
`define REG_SAMPLE_PHASE        4'hB
`define REG_CLOCK_GENERATOR     4'hC
`define REG_GENERAL_CONTROL_TWO 4'hD
`define REG_LAST                4'hE
`define REG_COUNT               15
// general_control_one fields
`define BIT_PORT_SPLIT          7
`define BIT_SIMULTANEOUS        6
`define BIT_LINE_SYNC_POL       5
`define BIT_HOLD_POL            4
`define BIT_CLAMP_SOURCE        3
`define BIT_CLAMP_POL           2
`define BIT_EXT_PIXEL_CLOCK     1
// sample_phase_control, clock_generator_control fields
`define PHASE_HI                7
`define PHASE_LO                3
`define BAND_HI                 6
`define BAND_LO                 5
`define PUMP_HI                 4
`define PUMP_LO                 2
// general_control_two fields
`define BIT_FIRST_PORT_WR       4
`define BIT_FIRST_PORT_RD       7
`define REV_HI                  3
`define REV_LO                  1
// Power-up values
`define RST_PLL_DIV_HIGH        8'h69
`define RST_PLL_DIV_LOW         8'hD0
`define RST_MID_SCALE           8'h80
`define RST_GENERAL_ONE         8'hF4
`define RST_CLOCK_GENERATOR     8'h24
`define RST_ZERO                8'h00
// Serial slave address, upper five bits fixed
`define SLAVE_ADDR_HIGH         5'h13
`endif

// file: src/video_capture_serial_control.v
`include "video_capture_serial_control_map.vh"
`default_nettype none
module video_capture_serial_control #(
	parameter [2:0] DIE_REVISION = 3'h1 // Arbitrary value
) (
	input  wire       clock,               // 40 MHz system clock
	input  wire       rst,                 // Synchronous reset
	input  wire       scl_in,              // Serial clock pin
	input  wire       sda_in,              // Serial data pin level
	output wire       sda_out,             // Serial data drive value
	output reg        sda_oe,              // Pull serial data low
	input  wire [1:0] address_select_pins, // Low slave address bits
	input  wire       line_sync_input,     // Line sync pin
	input  wire       pll_hold_input,      // PLL hold pin
	input  wire       clamp_pin,           // External clamp pin
	input  wire       external_clock_pin,  // External pixel clock pin
	input  wire       pixel_valid,         // Internal clock sample strobe
	input  wire [7:0] pixel_in,            // Converted sample
	output reg  [7:0] port_a_data,         // Output port A
	output reg  [7:0] port_b_data,         // Output port B
	output wire       port_b_oe,           // Port B drive enable
	output reg        data_clock_out,      // Output data clock
	output reg        clamp_active,        // Clamp the three channels
	output reg        pll_ref_sync,        // Sync fed to clock generator
	output wire       divider_enable,      // Line divider in use
	output wire [4:0] sample_phase,        // Sampling phase step
	output wire [1:0] oscillator_band,     // Generator range
	output wire [2:0] charge_pump_current  // Charge pump code
);

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_RX   = 3'h1;
	localparam [2:0] ST_ACK  = 3'h2;
	localparam [2:0] ST_TX   = 3'h3;
	localparam [2:0] ST_RACK = 3'h4;
	localparam [2:0] ST_SKIP = 3'h5;
	localparam [1:0] K_ADDR  = 2'h0;
	localparam [1:0] K_PTR   = 2'h1;
	localparam [1:0] K_DATA  = 2'h2;
	localparam [1:0] CL_OFF  = 2'h0;
	localparam [1:0] CL_WAIT = 2'h1;
	localparam [1:0] CL_ON   = 2'h2;

	reg  [7:0] regs [0:`REG_COUNT-1];
	reg  [7:0] sync_a;
	reg  [7:0] sync_b;
	wire [1:0] addr_pins;
	reg        scl_d;
	reg        sda_d;
	reg        line_d;
	reg        ext_clk_d;
	reg  [2:0] state;
	reg  [1:0] kind;
	reg  [3:0] bit_cnt;
	reg  [7:0] shreg;
	reg  [3:0] pointer;
	reg        reading;
	reg        master_nack;
	reg        phase;
	reg  [7:0] a_hold;
	reg  [1:0] clamp_state;
	reg  [7:0] clamp_cnt;
	wire       scl_s;
	wire       sda_s;
	wire       line_s;
	wire       hold_s;
	wire       clamp_s;
	wire       ext_clk_s;
	wire       scl_rise;
	wire       scl_fall;
	wire       start_seen;
	wire       stop_seen;
	wire [7:0] ctl_one;
	wire       split;
	wire       first_port;
	wire       line_active;
	wire       line_active_d;
	wire       lead_edge;
	wire       trail_edge;
	wire       hold_active;
	wire       pixel_strobe;
	wire       to_a;
	wire [3:0] next_pointer;
	wire [7:0] read_value;
	integer    i;

	// Two-stage synchronisers for all pins
	assign scl_s     = sync_b[0];
	assign sda_s     = sync_b[1];
	assign line_s    = sync_b[2];
	assign hold_s    = sync_b[3];
	assign clamp_s   = sync_b[4];
	assign ext_clk_s = sync_b[5];
	assign addr_pins = sync_b[7:6];

	always @(posedge clock) begin
		if (rst) begin
			// Bus pins idle high, others idle low
			sync_a    <= 8'h03;
			sync_b    <= 8'h03;
			scl_d     <= 1'b1;
			sda_d     <= 1'b1;
			line_d    <= 1'b0;
			ext_clk_d <= 1'b0;
		end else begin
			sync_a    <= {address_select_pins, external_clock_pin, clamp_pin,
				pll_hold_input, line_sync_input, sda_in, scl_in};
			sync_b    <= sync_a;
			scl_d     <= scl_s;
			sda_d     <= sda_s;
			line_d    <= line_s;
			ext_clk_d <= ext_clk_s;
		end
	end

	assign ctl_one    = regs[`REG_GENERAL_CONTROL_ONE];
	assign split      = ctl_one[`BIT_PORT_SPLIT];
	assign first_port = regs[`REG_GENERAL_CONTROL_TWO][`BIT_FIRST_PORT_WR];
	assign scl_rise   = scl_s & ~scl_d;
	assign scl_fall   = ~scl_s & scl_d;
	// Start and stop detection
	// start while SCL high
	assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_seen  = scl_s & scl_d & ~sda_d & sda_s;

	assign next_pointer = (pointer == `REG_LAST) ? pointer : pointer + 4'h1;

	assign read_value = (pointer == `REG_GENERAL_CONTROL_TWO) ?
		{first_port, 3'h0, DIE_REVISION, 1'b0} : regs[pointer];

	assign sda_out = 1'b0;

	// Serial slave and register file
	always @(posedge clock) begin
		if (rst) begin
			state       <= ST_IDLE;
			kind        <= K_ADDR;
			bit_cnt     <= 4'h0;
			shreg       <= 8'h00;
			pointer     <= 4'h0;
			reading     <= 1'b0;
			master_nack <= 1'b0;
			sda_oe      <= 1'b0;
			for (i = 0; i < `REG_COUNT; i = i + 1) begin
				regs[i] <= `RST_MID_SCALE;
			end
			regs[`REG_PLL_DIV_HIGH]        <= `RST_PLL_DIV_HIGH;
			regs[`REG_PLL_DIV_LOW]         <= `RST_PLL_DIV_LOW;
			regs[`REG_GENERAL_CONTROL_ONE] <= `RST_GENERAL_ONE;
			regs[`REG_CLOCK_GENERATOR]     <= `RST_CLOCK_GENERATOR;
			regs[`REG_GENERAL_CONTROL_TWO] <= `RST_ZERO;
			regs[`REG_LAST]                <= `RST_ZERO;
		end else if (start_seen) begin
			state   <= ST_RX;
			kind    <= K_ADDR;
			bit_cnt <= 4'h0;
			sda_oe  <= 1'b0;
		end else if (stop_seen) begin
			state  <= ST_IDLE;
			sda_oe <= 1'b0;
		end else begin
			case (state)
			ST_RX: begin
				if (scl_rise) begin
					shreg   <= {shreg[6:0], sda_s};
					bit_cnt <= bit_cnt + 4'h1;
				end else if (scl_fall && bit_cnt == 4'h8) begin
					state  <= ST_ACK;
					sda_oe <= 1'b1;
					if (kind == K_ADDR) begin
						reading <= shreg[0];
						if (shreg[7:1] != {`SLAVE_ADDR_HIGH, addr_pins}) begin
							state  <= ST_SKIP;
							sda_oe <= 1'b0;
						end
					end else if (kind == K_PTR) begin
						if (shreg > {4'h0, `REG_LAST}) begin
							state  <= ST_SKIP;
							sda_oe <= 1'b0;
						end else begin
							pointer <= shreg[3:0];
						end
					end else begin
						if (pointer == `REG_GENERAL_CONTROL_TWO) begin
							regs[pointer] <= shreg & 8'h10;
						end else begin
							regs[pointer] <= shreg;
						end
					end
				end
			end
			ST_ACK: begin
				if (scl_fall) begin
					bit_cnt <= 4'h0;
					if (kind == K_ADDR && reading) begin
						state  <= ST_TX;
						shreg  <= {read_value[6:0], 1'b0};
						sda_oe <= ~read_value[7];
					end else begin
						state  <= ST_RX;
						sda_oe <= 1'b0;
						if (kind == K_ADDR) begin
							kind <= K_PTR;
						end else begin
							kind <= K_DATA;
						end
						if (kind == K_DATA) begin
							pointer <= next_pointer;
						end
					end
				end
			end
			ST_TX: begin
				if (scl_fall) begin
					bit_cnt <= bit_cnt + 4'h1;
					if (bit_cnt == 4'h7) begin
						state   <= ST_RACK;
						sda_oe  <= 1'b0;
						pointer <= next_pointer;
					end else begin
						sda_oe <= ~shreg[7];
						shreg  <= {shreg[6:0], 1'b0};
					end
				end
			end
			ST_RACK: begin
				if (scl_rise) begin
					master_nack <= sda_s;
				end else if (scl_fall) begin
					bit_cnt <= 4'h0;
					if (master_nack) begin
						state  <= ST_SKIP;
						sda_oe <= 1'b0;
					end else begin
						state  <= ST_TX;
						shreg  <= {read_value[6:0], 1'b0};
						sda_oe <= ~read_value[7];
					end
				end
			end
			ST_SKIP: begin
				sda_oe <= 1'b0;
			end
			default: begin
				sda_oe <= 1'b0;
			end
			endcase
		end
	end

	assign line_active   = line_s ~^ ctl_one[`BIT_LINE_SYNC_POL];
	assign line_active_d = line_d ~^ ctl_one[`BIT_LINE_SYNC_POL];
	assign lead_edge     = line_active & ~line_active_d;
	assign trail_edge    = ~line_active & line_active_d;
	assign hold_active   = hold_s ~^ ctl_one[`BIT_HOLD_POL];
	assign pixel_strobe  = ctl_one[`BIT_EXT_PIXEL_CLOCK] ?
		(ext_clk_s & ~ext_clk_d) : pixel_valid;
	assign divider_enable = ~ctl_one[`BIT_EXT_PIXEL_CLOCK];

	assign sample_phase        = regs[`REG_SAMPLE_PHASE][`PHASE_HI:`PHASE_LO];
	assign oscillator_band     = regs[`REG_CLOCK_GENERATOR][`BAND_HI:`BAND_LO];
	assign charge_pump_current = regs[`REG_CLOCK_GENERATOR][`PUMP_HI:`PUMP_LO];

	// port B floats in single mode
	assign port_b_oe = split;
	assign to_a = ((phase & ~lead_edge) == first_port);

	// Output steering
	always @(posedge clock) begin
		if (rst) begin
			phase          <= 1'b0;
			a_hold         <= 8'h00;
			port_a_data    <= 8'h00;
			port_b_data    <= 8'h00;
			data_clock_out <= 1'b0;
			pll_ref_sync   <= 1'b0;
		end else begin
			pll_ref_sync <= line_active & ~hold_active & divider_enable;
			if (lead_edge & ~pixel_strobe) begin
				phase <= 1'b0;
			end else if (pixel_strobe) begin
				phase          <= ~(phase & ~lead_edge);
				data_clock_out <= ~data_clock_out;
				if (!split) begin
					port_a_data <= pixel_in;
				end else if (to_a) begin
					if (ctl_one[`BIT_SIMULTANEOUS]) begin
						a_hold <= pixel_in;
					end else begin
						port_a_data <= pixel_in;
					end
				end else begin
					port_b_data <= pixel_in;
					if (ctl_one[`BIT_SIMULTANEOUS]) begin
						port_a_data <= a_hold;
					end
				end
			end
		end
	end

	// Clamp generation
	always @(posedge clock) begin
		if (rst) begin
			clamp_state  <= CL_OFF;
			clamp_cnt    <= 8'h00;
			clamp_active <= 1'b0;
		end else begin
			if (ctl_one[`BIT_CLAMP_SOURCE]) begin
				clamp_active <= clamp_s ~^ ctl_one[`BIT_CLAMP_POL];
			end else begin
				clamp_active <= (clamp_state == CL_ON);
			end
			if (trail_edge) begin
				clamp_state <= CL_WAIT;
				clamp_cnt   <= regs[`REG_CLAMP_START];
			end else if (pixel_strobe) begin
				case (clamp_state)
				CL_WAIT: begin
					if (clamp_cnt == 8'h01) begin
						clamp_state <= CL_ON;
						clamp_cnt   <= regs[`REG_CLAMP_LENGTH];
					end else begin
						clamp_cnt <= clamp_cnt - 8'h01;
					end
				end
				CL_ON: begin
					if (clamp_cnt == 8'h01) begin
						clamp_state <= CL_OFF;
					end else begin
						clamp_cnt <= clamp_cnt - 8'h01;
					end
				end
				default: begin
					clamp_state <= CL_OFF;
				end
				endcase
			end
		end
	end

endmodule // video_capture_serial_control
`default_nettype wire

// file: dv/serial_control_sva.sv
`default_nettype none
module serial_control_sva (
	input wire logic       clock,          // Clock
	input wire logic       rst,            // Reset
	input wire logic       scl_in,         // Serial clock
	input wire logic       sda_out,        // Data drive value
	input wire logic       sda_oe,         // Data pull low
	input wire logic       pixel_valid,    // Sample strobe
	input wire logic [7:0] pixel_in,       // Sample
	input wire logic [7:0] port_a_data,    // Port A
	input wire logic [7:0] port_b_data,    // Port B
	input wire logic       port_b_oe,      // Port B enable
	input wire logic       data_clock_out, // Data clock
	input wire logic       pll_ref_sync,   // Generator sync
	input wire logic       divider_enable  // Internal clock
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	AST_SDA_LOW_ONLY: assert property (sda_out == 1'b0)
		else $error("data drive value not low");
	AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !$past(scl_in, 2))
		else $error("data drive changed with clock high");
	AST_ACK_HOLD: assert property ($rose(sda_oe) |-> sda_oe [*7])
		else $error("data drive too short");
	AST_PORTB_QUIET: assert property (!port_b_oe && $past(port_b_oe) == 1'b0
		|-> $stable(port_b_data))
		else $error("port B moved in single mode");
	AST_SINGLE_TO_A: assert property (pixel_valid && !port_b_oe && divider_enable
		|=> port_a_data == $past(pixel_in))
		else $error("sample missing on port A");
	AST_DCLK_ON_STROBE: assert property (pixel_valid && divider_enable
		|=> data_clock_out != $past(data_clock_out))
		else $error("data clock did not toggle");
	AST_DCLK_ONLY_STROBE: assert property ($changed(data_clock_out) && divider_enable
		|-> $past(pixel_valid))
		else $error("data clock toggled without sample");
	AST_EXT_NO_REF: assert property (!divider_enable && $past(divider_enable) == 1'b0
		|-> !pll_ref_sync)
		else $error("sync reached generator in external mode");
	AST_COMMIT_AT_ACK: assert property ($changed(port_b_oe) |-> ##[0:1] sda_oe)
		else $error("register changed outside acknowledge");
	cover property (pixel_valid && port_b_oe);
	cover property ($rose(sda_oe));
	cover property (!divider_enable);
endmodule // serial_control_sva

bind video_capture_serial_control serial_control_sva serial_control_sva_inst (
	.clock(clock), .rst(rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.pixel_valid(pixel_valid), .pixel_in(pixel_in), .port_a_data(port_a_data),
	.port_b_data(port_b_data), .port_b_oe(port_b_oe), .data_clock_out(data_clock_out),
	.pll_ref_sync(pll_ref_sync), .divider_enable(divider_enable)
);
`default_nettype wire

// file: dv/serial_master.sv
`default_nettype none
module serial_master (
	input  wire logic clock,    // Bench clock
	input  wire logic sda_line, // Resolved data wire
	output var logic  scl,      // Serial clock
	output var logic  pull      // Pull data low
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end
	task automatic bit_io(input logic b, output logic r);
		@(posedge clock) scl <= 1'b0;
		@(posedge clock) pull <= !b;
		repeat (3) @(posedge clock);
		scl <= 1'b1;
		repeat (3) @(posedge clock);
		r = sda_line;
	endtask
	task automatic cond(input logic s);
		@(posedge clock) scl <= 1'b0;
		@(posedge clock) pull <= !s;
		repeat (3) @(posedge clock);
		scl <= 1'b1;
		repeat (4) @(posedge clock);
		pull <= s;
		repeat (4) @(posedge clock);
	endtask
	task automatic xfer(input logic [7:0] b, input logic m, output logic [7:0] d,
		output logic a);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], d[i]);
		bit_io(m, r);
		a = !r;
	endtask
endmodule // serial_master
`default_nettype wire

// file: dv/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [2:0] REV = 3'h5; // Arbitrary value
	localparam logic [7:0] ADR = 8'h9C;
	logic       clock, rst, scl, pull, sda_line, sda_out, sda_oe, a, ext_clk, dck;
	logic [1:0] sel;
	logic       line_sync_input, pll_hold_input, clamp_pin, pixel_valid;
	logic       port_b_oe, data_clock_out, clamp_active, pll_ref_sync, divider_enable;
	logic [7:0] pixel_in, port_a_data, port_b_data, x;
	logic [7:0] dat [0:4];
	logic [4:0] sample_phase;
	logic [1:0] oscillator_band;
	logic [2:0] charge_pump_current;
	int         fails, check_count, cycles;
	assign sda_line = (sda_oe ? sda_out : 1'b1) & !pull;
	video_capture_serial_control #(.DIE_REVISION(REV)) video_capture_serial_control_inst (
		.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe(sda_oe), .address_select_pins(sel), .line_sync_input(line_sync_input),
		.pll_hold_input(pll_hold_input), .clamp_pin(clamp_pin), .external_clock_pin(ext_clk),
		.pixel_valid(pixel_valid), .pixel_in(pixel_in), .port_a_data(port_a_data),
		.port_b_data(port_b_data), .port_b_oe(port_b_oe), .data_clock_out(data_clock_out),
		.clamp_active(clamp_active), .pll_ref_sync(pll_ref_sync),
		.divider_enable(divider_enable), .sample_phase(sample_phase),
		.oscillator_band(oscillator_band), .charge_pump_current(charge_pump_current));
	serial_master serial_master_inst (.clock(clock), .sda_line(sda_line), .scl(scl),
		.pull(pull));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = !clock;
	end
	task automatic give_verdict;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			give_verdict;
		end
	end
	task automatic chk(input logic s, input logic e, input string n);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s exp %b got %b", n, e, s);
		end
	endtask
	task automatic chk8(input logic [7:0] s, input logic [7:0] e, input string n);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask
	// Pointer write, then n data writes or a repeated-start read
	task automatic acc(input logic [7:0] p, input int n, input logic rd);
		serial_master_inst.cond(1'b1);
		serial_master_inst.xfer(ADR, 1'b1, x, a);
		chk(a, 1'b1, "address ack");
		serial_master_inst.xfer(p, 1'b1, x, a);
		chk(a, p < 8'h0F, "pointer ack");
		if (rd) begin
			serial_master_inst.cond(1'b1);
			serial_master_inst.xfer(ADR | 8'h01, 1'b1, x, a);
			chk(a, 1'b1, "read address ack");
		end
		for (int i = 0; i < n; i++) begin
			serial_master_inst.xfer(rd ? 8'hFF : dat[i], rd ? i == n - 1 : 1'b1, x, a);
			if (rd)
				chk8(x, dat[i], "read data");
			else
				chk(a, 1'b1, "data ack");
		end
		serial_master_inst.cond(1'b0);
	endtask
	task automatic sync(input logic e);
		@(posedge clock) line_sync_input <= 1'b1;
		repeat (6) @(posedge clock);
		chk(pll_ref_sync, e, "generator sync");
		line_sync_input <= 1'b0;
		repeat (6) @(posedge clock);
	endtask
	task automatic pix(input logic [7:0] v);
		@(posedge clock) pixel_valid <= 1'b1;
		pixel_in <= v;
		@(posedge clock) pixel_valid <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
	initial begin
		rst = 1'b1;
		line_sync_input = 1'b0;
		pll_hold_input = 1'b0;
		clamp_pin = 1'b0;
		sel = 2'b10;
		ext_clk = 1'b0;
		pixel_valid = 1'b0;
		pixel_in = 8'h00;
		fails = 0;
		check_count = 0;
		cycles = 0;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		chk8({3'h0, sample_phase}, 8'h10, "phase");
		chk8({6'h0, oscillator_band}, 8'h01, "band");
		chk8({5'h0, charge_pump_current}, 8'h01, "pump");
		dat = '{8'hF4, 8'h80, 8'h24, {4'h0, REV, 1'b0}, 8'h00};
		acc(8'h0A, 5, 1'b1);
		for (int j = 0; j < 2; j++) begin
			sel <= j[0] ? 2'b00 : 2'b10;
			serial_master_inst.cond(1'b1);
			serial_master_inst.xfer(8'h98, 1'b1, x, a);
			chk(a, j[0], "address select");
			serial_master_inst.cond(1'b0);
		end
		sel <= 2'b10;
		acc(8'h0F, 0, 1'b0);
		dat = '{8'h48, 8'h7C, 8'h10, 8'h55, 8'hAA};
		acc(8'h0B, 5, 1'b0);
		chk8({3'h0, sample_phase}, 8'h09, "phase");
		chk8({6'h0, oscillator_band}, 8'h03, "band");
		chk8({5'h0, charge_pump_current}, 8'h07, "pump");
		dat = '{8'h48, 8'h7C, {4'h8, REV, 1'b0}, 8'hAA, 8'h00};
		acc(8'h0B, 4, 1'b1);
		dat[0] = 8'hBC;
		acc(8'h0A, 1, 1'b0);
		for (int i = 0; i < 2; i++) begin
			clamp_pin <= i[0];
			repeat (6) @(posedge clock);
			chk(clamp_active, i[0], "external clamp");
		end
		pll_hold_input <= 1'b1;
		sync(1'b0);
		pll_hold_input <= 1'b0;
		sync(1'b1);
		pix(8'h11);
		chk8(port_b_data, 8'h11, "first sample");
		pix(8'h22);
		chk8(port_a_data, 8'h22, "second sample");
		dat[0] = 8'hFC;
		acc(8'h0A, 1, 1'b0);
		sync(1'b1);
		pix(8'h44);
		pix(8'h55);
		pix(8'h66);
		chk8(port_a_data, 8'h55, "simultaneous A");
		chk8(port_b_data, 8'h66, "simultaneous B");
		dat = '{8'h02, 8'h03, 8'hB4, 8'h00, 8'h00};
		acc(8'h08, 3, 1'b0);
		sync(1'b1);
		pix(8'h01);
		pix(8'h02);
		chk(clamp_active, 1'b1, "internal clamp on");
		for (int i = 0; i < 3; i++) pix(8'h03);
		chk(clamp_active, 1'b0, "internal clamp off");
		dat[0] = 8'h3C;
		acc(8'h0A, 1, 1'b0);
		chk(port_b_oe, 1'b0, "port B enable");
		pix(8'h33);
		chk8(port_a_data, 8'h33, "single sample");
		dat[0] = 8'h3E;
		acc(8'h0A, 1, 1'b0);
		chk(divider_enable, 1'b0, "divider enable");
		pixel_in <= 8'h77;
		dck = data_clock_out;
		ext_clk <= 1'b1;
		repeat (6) @(posedge clock);
		chk8(port_a_data, 8'h77, "external strobe");
		chk(data_clock_out, !dck, "data clock");
		ext_clk <= 1'b0;
		sync(1'b0);
		rst <= 1'b1;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		chk(port_b_oe, 1'b1, "reset split");
		chk(divider_enable, 1'b1, "reset clock select");
		chk8({3'h0, sample_phase}, 8'h10, "reset phase");
		give_verdict;
	end
endmodule // tb_top
`default_nettype wire
